// ==== fmme_entry.sv ====
/*
  Reset time mode logic: chooses user or monitor mode, forces a second
  reset on a blank reset vector, remaps vectors, gates the watchdog and
  sets the monitor pin roles. Assumes resetn_i is the power-on reset,
  and that pins and the high voltage detector are asynchronous levels.
*/
// Operation
// (R01) blank vector entry adds one extra reset
// (R02) programmed vector: host applies test voltage
// (R03) forced monitor keeps watchdog off always
// (R04) both reset vector bytes erased: internal reset
// (R05) forced monitor runs untrimmed internal oscillator
// (R06) interrupt pin high: serial bit0, clock bit5
// (R07) interrupt pin low: only bit0 serial
// (R08) monitor: port A bit 2 reads zero
// (R09) monitor: pin branches act as enabled
// (R10) only power-on reset leaves forced monitor
// (R11) monitor fetches vectors from monitor page
// (R12) forced entry skips startup pin checks
// (R13) forced flag set on blank, power-on clears
`default_nettype none

module fmme_entry
  import fmme_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                ext_rst_pin_n_i,
  input  wire logic                irq_pin_i,
  input  wire logic                irq_hv_det_i,
  input  wire logic                wdog_rst_req_i,
  input  wire logic                cfg_irq_pin_en_i,
  input  wire logic                cfg_wdog_en_i,
  input  wire logic                vec_fetch_i,
  input  wire logic [15:0]         cpu_addr_i,
  input  wire logic                rd_valid_i,
  input  wire logic [15:0]         rd_addr_i,
  input  wire logic [7:0]          rd_data_i,
  input  wire logic [fmme_pkg::PTA_W-1:0] pta_pin_i,
  output logic                     core_rst_n_o,
  output logic [15:0]              mem_addr_o,
  output logic                     monitor_mode_o,
  output logic                     forced_monitor_o,
  output logic                     watchdog_timer_en_o,
  output logic                     osc_trim_default_o,
  output logic                     port_a_bit0_serial_en_o,
  output logic                     port_a_bit5_clock_in_en_o,
  output logic                     pins_default_input_o,
  output logic [fmme_pkg::PTA_W-1:0] pta_rd_o,
  output logic                     irq_branch_en_o,
  output logic                     startup_pin_check_en_o
);

  import fmme_pkg::*;

  // ==========================================================================
  // declarations
  // ==========================================================================
  localparam logic [RST_CNT_W-1:0] HOLD_LAST = RST_CNT_W'(RST_HOLD_CYC - 1);

  logic [PIN_W-1:0]     pin_s;     // synchronised pin levels
  logic                 ext_rst_s; // external reset asserted
  logic                 irq_s;     // interrupt pin level
  logic                 hv_s;      // test_high_voltage present
  logic                 erased_s;  // blank reset vector pulse
  logic                 rst_src;   // any reset request this cycle
  logic                 mon;       // monitor mode, either kind
  logic                 arm;       // vector check allowed
  fmme_state_t          state_q;   // reset sequencer state
  fmme_state_t          state_d;
  logic [RST_CNT_W-1:0] cnt_q;     // cycles spent in hold
  logic [RST_CNT_W-1:0] cnt_d;
  logic                 hv_mon_q;  // entered with test voltage
  logic                 irq_hi_q;  // interrupt pin level at release
  logic [PTA_W-1:0]     pta_mask;  // port read mask

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  fmme_sync #(
    .WIDTH   (PIN_W),
    .RST_VAL (PIN_SYNC_RST)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    ({ext_rst_pin_n_i, irq_pin_i, irq_hv_det_i, pta_pin_i}),
    .sync_o     (pin_s)
  );

  assign ext_rst_s = !pin_s[PIN_RSTN];
  assign irq_s     = pin_s[PIN_IRQ];
  assign hv_s      = pin_s[PIN_HV];

  // ==========================================================================
  // blank vector detector
  // ==========================================================================
  // only armed in user mode; monitor vectors live elsewhere
  assign arm = (state_q == FMME_RUN) && !mon;  // R04

  fmme_vec_check u_vec_check (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .arm_i      (arm),
    .rd_valid_i (rd_valid_i),
    .rd_addr_i  (rd_addr_i),
    .rd_data_i  (rd_data_i),
    .erased_o   (erased_s)
  );

  // ==========================================================================
  // reset sequencer
  // ==========================================================================
  // every source, the blank vector among them, restarts the hold
  assign rst_src = ext_rst_s || wdog_rst_req_i || erased_s;  // R01

  // next state and hold count
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      FMME_HOLD: begin
        if (rst_src) begin
          cnt_d = '0;              // reset source still active: stretch
        end else if (cnt_q == HOLD_LAST) begin
          state_d = FMME_RUN;      // release the core
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      FMME_RUN: begin
        if (rst_src) begin
          state_d = FMME_HOLD;     // R01
          cnt_d   = '0;
        end
      end
    endcase
  end

  // power-on starts in hold, so the first release is counted too
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= FMME_HOLD;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // core reset follows the next state, so it lines up with state_q
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_rst_n_o <= 1'b0;
    end else begin
      core_rst_n_o <= (state_d == FMME_RUN);
    end
  end

  // ==========================================================================
  // mode flags
  // ==========================================================================
  // forced flag: set only, nothing but power-on clears it
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      forced_monitor_o <= 1'b0;    // R13
    end else if (erased_s) begin
      forced_monitor_o <= 1'b1;    // R13 R10
    end
  end

  // straps caught at each release, not under the async reset
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hv_mon_q <= 1'b0;
      irq_hi_q <= 1'b0;
    end else if (state_q == FMME_HOLD && state_d == FMME_RUN) begin
      hv_mon_q <= hv_s;            // R02
      irq_hi_q <= irq_s;
    end
  end

  assign mon = forced_monitor_o || hv_mon_q;

  // ==========================================================================
  // mode outputs
  // ==========================================================================
  // watchdog: forced entry ignores the pin, voltage entry follows it
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      monitor_mode_o      <= 1'b0;
      watchdog_timer_en_o <= 1'b0;
      osc_trim_default_o  <= 1'b0;
    end else begin
      monitor_mode_o      <= mon;
      watchdog_timer_en_o <= cfg_wdog_en_i && !forced_monitor_o && !(hv_mon_q && hv_s);  // R03
      osc_trim_default_o  <= forced_monitor_o;  // R05
    end
  end

  // startup pin demands only make sense with the test voltage path
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      startup_pin_check_en_o <= 1'b1;
    end else begin
      startup_pin_check_en_o <= !forced_monitor_o;  // R12
    end
  end

  // ==========================================================================
  // pin roles
  // ==========================================================================
  // all plain inputs in monitor, bit0 serial, bit5 clock if pin high
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pins_default_input_o      <= 1'b0;
      port_a_bit0_serial_en_o   <= 1'b0;
      port_a_bit5_clock_in_en_o <= 1'b0;
    end else begin
      pins_default_input_o      <= mon;              // R06 R07
      port_a_bit0_serial_en_o   <= mon;              // R06 R07
      port_a_bit5_clock_in_en_o <= mon && irq_hi_q;  // R06 R07
    end
  end

  // interrupt pin never shows as port data in monitor
  always_comb begin
    pta_mask              = '1;
    pta_mask[PTA_IRQ_BIT] = !mon;  // R08
  end

  // pin level branches: config bit overridden in monitor
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pta_rd_o        <= '0;
      irq_branch_en_o <= 1'b0;
    end else begin
      pta_rd_o        <= pin_s[PTA_W-1:0] & pta_mask;  // R08
      irq_branch_en_o <= mon || cfg_irq_pin_en_i;      // R09
    end
  end

  // ==========================================================================
  // vector remap
  // ==========================================================================
  // reset, software_interrupt and break pairs move to the monitor page;
  // costs one cycle of address latency on every fetch
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_addr_o <= '0;
    end else if (mon && vec_fetch_i && cpu_addr_i[15:8] == USER_VEC_PAGE &&
                 (cpu_addr_i[7:1] == RST_VEC_HI[7:1] ||
                  cpu_addr_i[7:1] == SWI_VEC_HI[7:1] ||
                  cpu_addr_i[7:1] == BRK_VEC_HI[7:1])) begin
      mem_addr_o <= {MON_VEC_PAGE, cpu_addr_i[7:0]};  // R11
    end else begin
      mem_addr_o <= cpu_addr_i;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  AST_EXTRA_RESET: assert property (  // R01
    @(posedge core_clk_i) disable iff (!resetn_i)
    erased_s |=> !core_rst_n_o [*2])
    else $error("blank vector did not give an extra reset");

  AST_BLANK_USER_ONLY: assert property (  // R04
    @(posedge core_clk_i) disable iff (!resetn_i)
    erased_s |-> !forced_monitor_o && core_rst_n_o)
    else $error("blank vector seen outside user run");

  AST_FORCED_SET: assert property (  // R13
    @(posedge core_clk_i) disable iff (!resetn_i)
    erased_s |=> forced_monitor_o)
    else $error("forced flag not set on blank vector");

  AST_FORCED_STICKY: assert property (  // R10
    @(posedge core_clk_i) disable iff (!resetn_i)
    forced_monitor_o && !core_rst_n_o |=> forced_monitor_o [*2])
    else $error("forced monitor lost on a reset");

  AST_WDOG_OFF: assert property (  // R03
    @(posedge core_clk_i) disable iff (!resetn_i)
    forced_monitor_o && $past(forced_monitor_o) |-> !watchdog_timer_en_o)
    else $error("watchdog enabled in forced monitor");

  AST_TRIM: assert property (  // R05
    @(posedge core_clk_i) disable iff (!resetn_i)
    $rose(forced_monitor_o) |=> osc_trim_default_o)
    else $error("oscillator trim not at default");

  AST_PIN_HI: assert property (  // R06
    @(posedge core_clk_i) disable iff (!resetn_i)
    forced_monitor_o && irq_hi_q |=> port_a_bit0_serial_en_o && port_a_bit5_clock_in_en_o)
    else $error("pin roles wrong with interrupt pin high");

  AST_PIN_LO: assert property (  // R07
    @(posedge core_clk_i) disable iff (!resetn_i)
    forced_monitor_o && !irq_hi_q |=> port_a_bit0_serial_en_o && !port_a_bit5_clock_in_en_o)
    else $error("pin roles wrong with interrupt pin low");

  AST_PA2_ZERO: assert property (  // R08
    @(posedge core_clk_i) disable iff (!resetn_i)
    monitor_mode_o |-> !pta_rd_o[PTA_IRQ_BIT])
    else $error("port A bit 2 not zero in monitor");

  AST_BRANCH: assert property (  // R09
    @(posedge core_clk_i) disable iff (!resetn_i)
    monitor_mode_o |-> irq_branch_en_o)
    else $error("pin branches not enabled in monitor");

  AST_VEC_REMAP: assert property (  // R11
    @(posedge core_clk_i) disable iff (!resetn_i)
    mon && vec_fetch_i && fmme_vec_at(cpu_addr_i, USER_VEC_PAGE, RST_VEC_LO)
    |=> mem_addr_o[15:8] == MON_VEC_PAGE)
    else $error("reset vector not fetched from monitor page");

  AST_STARTUP: assert property (  // R12
    @(posedge core_clk_i) disable iff (!resetn_i)
    forced_monitor_o |=> !startup_pin_check_en_o)
    else $error("startup pin check active in forced monitor");

endmodule : fmme_entry

`default_nettype wire

// ==== fmme_entry_tb.sv ====
/*
  Self-checking bench for the mode entry logic: power-on, user mode,
  watchdog and pin resets, voltage entry, blank vector entry, remap.
  Assumes the flash model answers vector reads one cycle late.
*/
`default_nettype none

module fmme_entry_tb
  import fmme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // signals
  // ==========================================================================
  logic             core_clk_i, resetn_i, ext_rst_pin_n_i, irq_pin_i, irq_hv_det_i;
  logic             wdog_rst_req_i, cfg_irq_pin_en_i, cfg_wdog_en_i, vec_fetch_i;
  logic             rd_en, erased, rd_valid, mon_exp;
  logic [15:0]      cpu_addr_i, rd_addr, exp_w;
  logic [7:0]       rd_data;
  logic [PTA_W-1:0] pta_pin_i, pta_rd_o;
  logic [15:0]      mem_addr_o;
  logic             core_rst_n_o, monitor_mode_o, forced_monitor_o, watchdog_timer_en_o;
  logic             osc_trim_default_o, port_a_bit0_serial_en_o, port_a_bit5_clock_in_en_o;
  logic             pins_default_input_o, irq_branch_en_o, startup_pin_check_en_o;
  logic [15:0]      exp_q[$];   // expected mem_addr_o, one per cycle
  int               n_errors, checks, cyc;

  fmme_entry dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ext_rst_pin_n_i(ext_rst_pin_n_i),
    .irq_pin_i(irq_pin_i), .irq_hv_det_i(irq_hv_det_i), .wdog_rst_req_i(wdog_rst_req_i),
    .cfg_irq_pin_en_i(cfg_irq_pin_en_i), .cfg_wdog_en_i(cfg_wdog_en_i), .vec_fetch_i(vec_fetch_i),
    .cpu_addr_i(cpu_addr_i), .rd_valid_i(rd_valid), .rd_addr_i(rd_addr), .rd_data_i(rd_data),
    .pta_pin_i(pta_pin_i), .core_rst_n_o(core_rst_n_o), .mem_addr_o(mem_addr_o),
    .monitor_mode_o(monitor_mode_o), .forced_monitor_o(forced_monitor_o),
    .watchdog_timer_en_o(watchdog_timer_en_o), .osc_trim_default_o(osc_trim_default_o),
    .port_a_bit0_serial_en_o(port_a_bit0_serial_en_o),
    .port_a_bit5_clock_in_en_o(port_a_bit5_clock_in_en_o), .pins_default_input_o(pins_default_input_o),
    .pta_rd_o(pta_rd_o), .irq_branch_en_o(irq_branch_en_o), .startup_pin_check_en_o(startup_pin_check_en_o));

  fmme_flash_model flash_u (.core_clk_i(core_clk_i), .rd_en_i(rd_en), .addr_i(cpu_addr_i),
    .erased_i(erased), .rd_valid_o(rd_valid), .rd_addr_o(rd_addr), .rd_data_o(rd_data));

  // ==========================================================================
  // clock, timeout, report
  // ==========================================================================
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // ==========================================================================
  // drivers
  // ==========================================================================
  // one cycle of cpu address; note the remapped address expected
  task automatic step(input logic fetch, input logic [15:0] a);
    vec_fetch_i = fetch;
    rd_en       = fetch;
    cpu_addr_i  = a;
    exp_q.push_back((mon_exp && fetch && a[15:8] == 8'hff &&
      (a[7:1] == 7'h7f || a[7:1] == 7'h7e || a[7:1] == 7'h7b)) ? {8'hfe, a[7:0]} : a);
    @(negedge core_clk_i);
  endtask : step

  // random addresses below the vector page, no fetch
  task automatic idle(input int n);
    repeat (n) step(1'b0, 16'($urandom) & 16'h7fff);
  endtask : idle

  task automatic wait_core();
    int k;
    k = 0;
    while (core_rst_n_o !== 1'b1 && k < 40) begin
      idle(1);
      k++;
    end
    check(core_rst_n_o, 1'b1);
  endtask : wait_core

  task automatic por();
    mon_exp  = 1'b0;
    resetn_i = 1'b0;
    idle(12);
    check(forced_monitor_o, 1'b0);
    check(startup_pin_check_en_o, 1'b1);
    resetn_i = 1'b1;
    idle(RST_HOLD_CYC - 1);
    check(core_rst_n_o, 1'b0);
    idle(1);
    check(core_rst_n_o, 1'b1);
  endtask : por

  task automatic ext_reset();
    ext_rst_pin_n_i = 1'b0;
    idle(4);
    ext_rst_pin_n_i = 1'b1;
    idle(3);
    wait_core();
    idle(2);
  endtask : ext_reset

  // result watcher: mem_addr_o settles one cycle after its address
  always begin
    @(posedge core_clk_i);
    #1;
    if (exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      if (resetn_i === 1'b1) check(mem_addr_o, exp_w);
    end
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {resetn_i, irq_pin_i, irq_hv_det_i, wdog_rst_req_i, cfg_irq_pin_en_i} = 5'h00;
    {vec_fetch_i, rd_en, erased, mon_exp} = 4'h0;
    ext_rst_pin_n_i = 1'b1;
    cfg_wdog_en_i   = 1'b1;
    cpu_addr_i      = 16'h0000;
    pta_pin_i       = 6'h00;
    void'($urandom(73));
    @(negedge core_clk_i);
    por();
    // programmed vector: stays in user mode
    step(1'b1, 16'hfffe);
    step(1'b1, 16'hffff);
    idle(12);
    check(core_rst_n_o, 1'b1);
    check(monitor_mode_o, 1'b0);
    check(watchdog_timer_en_o, 1'b1);
    check(irq_branch_en_o, 1'b0);
    // user mode: pin branches follow the config bit
    cfg_irq_pin_en_i = 1'b1;
    idle(2);
    check(irq_branch_en_o, 1'b1);
    cfg_irq_pin_en_i = 1'b0;
    pta_pin_i = 6'($urandom);
    idle(5);
    check(pta_rd_o, pta_pin_i);
    // watchdog request resets the core
    wdog_rst_req_i = 1'b1;
    idle(1);
    wdog_rst_req_i = 1'b0;
    idle(2);
    check(core_rst_n_o, 1'b0);
    wait_core();
    // programmed vector: voltage needed for monitor mode
    irq_hv_det_i = 1'b1;
    ext_reset();
    check(monitor_mode_o, 1'b1);
    check(forced_monitor_o, 1'b0);
    irq_hv_det_i = 1'b0;
    ext_reset();
    check(monitor_mode_o, 1'b0);
    // blank vector with interrupt pin high
    erased    = 1'b1;
    irq_pin_i = 1'b1;
    por();
    step(1'b1, 16'hfffe);
    step(1'b1, 16'hffff);
    idle(4);
    check(forced_monitor_o, 1'b1);
    check(core_rst_n_o, 1'b0);
    wait_core();
    idle(2);
    check(monitor_mode_o, 1'b1);
    check(watchdog_timer_en_o, 1'b0);
    check(osc_trim_default_o, 1'b1);
    check(port_a_bit0_serial_en_o, 1'b1);
    check(port_a_bit5_clock_in_en_o, 1'b1);
    check(pins_default_input_o, 1'b1);
    check(startup_pin_check_en_o, 1'b0);
    check(irq_branch_en_o, 1'b1);
    pta_pin_i = 6'($urandom) | 6'h04;
    idle(5);
    check(pta_rd_o, pta_pin_i & 6'h3b);
    // vector remap, back to back, plus a non-vector fetch
    mon_exp = 1'b1;
    step(1'b1, 16'hfffe);
    step(1'b1, 16'hffff);
    step(1'b1, 16'hfffc);
    step(1'b1, 16'hfffd);
    step(1'b1, 16'hfff6);
    step(1'b1, 16'hfff7);
    step(1'b1, 16'hfffa);
    idle(2);
    check(core_rst_n_o, 1'b1);
    // pin reset with interrupt pin low keeps forced mode
    irq_pin_i = 1'b0;
    ext_reset();
    check(forced_monitor_o, 1'b1);
    check(port_a_bit0_serial_en_o, 1'b1);
    check(port_a_bit5_clock_in_en_o, 1'b0);
    wdog_rst_req_i = 1'b1;
    idle(1);
    wdog_rst_req_i = 1'b0;
    idle(3);
    wait_core();
    idle(2);
    check(monitor_mode_o, 1'b1);
    check(watchdog_timer_en_o, 1'b0);
    por();
    final_report();
  end

endmodule : fmme_entry_tb

`default_nettype wire

// ==== fmme_flash_model.sv ====
/*
  Behavioural flash model for the vector area: answers a read one cycle
  after its request, with the address beside the data.
  Assumes the bench raises rd_en_i only on the cycles it wants read.
*/
`default_nettype none

module fmme_flash_model (
  input  wire logic        core_clk_i,
  input  wire logic        rd_en_i,     // read request
  input  wire logic [15:0] addr_i,      // read address
  input  wire logic        erased_i,    // vector area blank
  output logic             rd_valid_o,  // data valid, one cycle
  output logic [15:0]      rd_addr_o,   // address of that data
  output logic [7:0]       rd_data_o    // read data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // read port
  // ==========================================================================
  initial begin
    rd_valid_o = 1'b0;
    rd_addr_o  = 16'h0000;
    rd_data_o  = 8'h00;
  end

  // one cycle answer; stale data is never left standing
  always @(posedge core_clk_i) begin
    rd_valid_o <= rd_en_i;
    if (rd_en_i) begin
      rd_addr_o <= addr_i;
      // programmed reset vector bytes never read as blank
      rd_data_o <= erased_i ? 8'hff : (addr_i[7:0] ^ 8'h5a);
    end else begin
      // inverted so a late sample cannot look valid
      rd_addr_o <= ~rd_addr_o;
      rd_data_o <= ~rd_data_o;
    end
  end

endmodule : fmme_flash_model

`default_nettype wire

// ==== fmme_pkg.sv ====
/*
  Shared constants, types and helpers for the forced monitor mode entry
  block: reset timing, vector page layout, port A layout, state encoding.
  Assumes a single 200 MHz core clock and 16-bit CPU addresses.
*/
`default_nettype none

package fmme_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 5;    // core clock period, 200 MHz
  localparam int RST_HOLD_NS   = 40;   // least length of one reset cycle
  // least time, so round up to whole cycles
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W     = 4;    // hold counter width

  // ==========================================================================
  // vector layout
  // ==========================================================================
  localparam logic [7:0] USER_VEC_PAGE = 8'hff;  // user vectors
  localparam logic [7:0] MON_VEC_PAGE  = 8'hfe;  // monitor vectors
  localparam logic [7:0] RST_VEC_HI    = 8'hfe;  // reset vector, high byte
  localparam logic [7:0] RST_VEC_LO    = 8'hff;  // reset vector, low byte
  localparam logic [7:0] SWI_VEC_HI    = 8'hfc;  // software_interrupt vector
  localparam logic [7:0] BRK_VEC_HI    = 8'hf6;  // break interrupt vector
  localparam logic [7:0] ERASED_BYTE   = 8'hff;  // blank flash content

  // ==========================================================================
  // port A layout
  // ==========================================================================
  localparam int PTA_W       = 6;   // port A data width
  localparam int PTA_IRQ_BIT = 2;   // data bit shared with the interrupt pin
  localparam int PIN_W       = PTA_W + 3;
  localparam int PIN_HV      = PTA_W;      // test_high_voltage detector
  localparam int PIN_IRQ     = PTA_W + 1;  // interrupt pin level
  localparam int PIN_RSTN    = PTA_W + 2;  // external reset pin, low active
  // reset pin synchroniser rests at "not asserted"
  localparam logic [PIN_W-1:0] PIN_SYNC_RST = 9'h100;

  // ==========================================================================
  // types and helpers
  // ==========================================================================
  typedef enum logic {
    FMME_HOLD,   // reset held to the core
    FMME_RUN     // core running
  } fmme_state_t;

  // true when addr is byte ofs of the given vector page
  function automatic logic fmme_vec_at(input logic [15:0] addr,
                                       input logic [7:0]  page,
                                       input logic [7:0]  ofs);
    fmme_vec_at = (addr == {page, ofs});
  endfunction : fmme_vec_at

endpackage : fmme_pkg

`default_nettype wire

// ==== fmme_sync.sv ====
/*
  Two flip-flop synchroniser for a bundle of asynchronous pin levels.
  Assumes each bit is an independent level; no word coherence is given.
*/
`default_nettype none

module fmme_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;  // first stage, read only by sync_o

  // ==========================================================================
  // two stages
  // ==========================================================================
  // first stage feeds nothing but the second
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : fmme_sync

`default_nettype wire

// ==== fmme_vec_check.sv ====
/*
  Watches the two reset vector byte reads in the user page and pulses
  once when both came back erased. Assumes read data arrives with its
  own address on the core clock, and arm_i drops during reset.
*/
`default_nettype none

module fmme_vec_check
  import fmme_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        arm_i,       // checking allowed (user mode run)
  input  wire logic        rd_valid_i,  // read data valid
  input  wire logic [15:0] rd_addr_i,   // address of that data
  input  wire logic [7:0]  rd_data_i,   // read data
  output logic             erased_o     // one-cycle pulse
);

  logic hi_seen_q;  // high byte fetched
  logic lo_seen_q;  // low byte fetched
  logic hi_ff_q;    // high byte was erased
  logic lo_ff_q;    // low byte was erased

  // ==========================================================================
  // byte capture
  // ==========================================================================
  // a second fetch overwrites, so a reprogram shows at once
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_seen_q <= 1'b0;
      lo_seen_q <= 1'b0;
      hi_ff_q   <= 1'b0;
      lo_ff_q   <= 1'b0;
    end else if (!arm_i) begin
      hi_seen_q <= 1'b0;
      lo_seen_q <= 1'b0;
    end else if (rd_valid_i) begin
      if (fmme_vec_at(rd_addr_i, USER_VEC_PAGE, RST_VEC_HI)) begin
        hi_seen_q <= 1'b1;
        hi_ff_q   <= (rd_data_i == ERASED_BYTE);  // R04
      end
      if (fmme_vec_at(rd_addr_i, USER_VEC_PAGE, RST_VEC_LO)) begin
        lo_seen_q <= 1'b1;
        lo_ff_q   <= (rd_data_i == ERASED_BYTE);  // R04
      end
    end
  end

  // ==========================================================================
  // verdict
  // ==========================================================================
  // both bytes needed: one blank byte alone is a legal vector
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erased_o <= 1'b0;
    end else begin
      erased_o <= arm_i && !erased_o && hi_seen_q && lo_seen_q && hi_ff_q && lo_ff_q;  // R04
    end
  end

endmodule : fmme_vec_check

`default_nettype wire
